// >>> host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic           mclk,
    input  wire logic [7:0]     rdata,
    output var rotary_pkg::reg_req_t req
);
    initial req = '0;
    task automatic issue(input bit s, input bit w, input bit r,
                         input logic [7:0] v, output logic [7:0] d);
        @(negedge mclk);
        req.set_ptr = s;
        req.wr = w;
        req.rd = r;
        req.ptr = v[3:0];
        req.wdata = v;
        @(posedge mclk);
        #1;
        d = rdata;
    endtask
endmodule // host_model
`default_nettype wire

// >>> rotary_cfg.svh
`ifndef ROTARY_CFG_SVH
`define ROTARY_CFG_SVH
`define ADDR_EVENT_QUEUE   4'h0
`define ADDR_FAULT         4'h1
`define ADDR_POSITION      4'h2
`define ADDR_FEATURE       4'h3
`define ADDR_THRESHOLD     4'h4
`define ADDR_TICK_PERIOD   4'h5
`define ADDR_SCAN_FACTOR   4'h6
`define ADDR_CLICK_TONE    4'h7
`define ADDR_POWER_SAVE    4'h8
`define ADDR_HELD_TIMEOUT  4'h9
`define ADDR_MODE_CONTROL  4'hA
`define ADDR_PART_INFO     4'hB
`define BIT_CLICK          7
`define BIT_SELF_CAL       4
`define BIT_LOG_RELEASE    3
`define BIT_LOG_TOUCH      2
`define BIT_DETECT         0
`define FEATURE_MASK       8'h9D
`define BIT_RUN            0
`define BIT_DOZE           2
`define RST_EVENT_QUEUE    8'h40
`define RST_FEATURE        8'h81
`define RST_THRESHOLD      8'h00
`define RST_TICK_PERIOD    8'h05
`define RST_SCAN_FACTOR    8'h01
`define RST_CLICK_TONE     8'h01
`define RST_POWER_SAVE     8'h00
`define RST_HELD_TIMEOUT   8'h00
`define RST_MODE_CONTROL   8'h14
`define SCAN_FACTOR_MAX    8'h1F
`define MARGIN_DEFAULT     8'h10
`define EVT_RELEASE_FLAG   7
`endif

// >>> rotary_pkg.sv
package rotary_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       set_ptr;
        logic [3:0] ptr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } event_t;
    typedef enum logic [1:0] {IDLE, HELD, WAIT_FREE} track_t;
endpackage

// >>> rotary_touch_decode_regmap.sv
// What this block does
// (RULE1) twelve 8-bit registers selected by a stored pointer for the host
// (RULE2) burst pointer goes 0x01 to 0x02 and 0x03..0x09 up to 0x0A
// (RULE3) burst pointer wraps to 0x00 after 0x00, 0x02, 0x0A; stays at 0x0B
// (RULE4) report untouched or exactly one of eight pads
// (RULE5) touch between pads with no clear winner reports untouched
// (RULE6) pad counts only when strength exceeds the threshold
// (RULE7) several qualifying pads of similar strength report untouched
// (RULE8) clearly stronger pad among two wins the report
// (RULE9) second pad touched while first held is ignored
// (RULE10) later pad released while first held gives no report
// (RULE11) first released while later held: release then later touched
// (RULE12) feature bit 7 gates click output to the sounder
// (RULE13) feature bit 4 enables self calibration
// (RULE14) feature bit 3 logs release events to the queue
// (RULE15) feature bit 2 logs touch events to the queue
// (RULE16) feature bit 0 enables detection, else no touches
// (RULE17) scan factor is encoding plus one, 1 to 32
// (RULE18) scan factor writes above range force 00011111
// (RULE19) scan period is factor times master tick
// (RULE20) pointer advances after each read with the same table
// (RULE21) config writes accepted only in halted bus active mode
// (RULE22) feature bits 6, 5, 1 ignore writes and read zero
`include "rotary_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rotary_touch_decode_regmap #(
    parameter int          PADS   = 8,
    parameter logic [7:0]  MARGIN = `MARGIN_DEFAULT,
    parameter logic [7:0]  PART_INFO_VALUE = 8'h5A // arbitrary value
) (
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic               tick,
    input  wire rotary_pkg::reg_req_t req,
    input  wire logic [PADS*8-1:0]  strength,
    input  wire logic               event_ready,
    output logic [7:0]              rdata,
    output logic [3:0]              ptr,
    output logic                    scan_strobe,
    output logic                    click,
    output logic                    self_cal_enable,
    output rotary_pkg::event_t      event_out,
    output logic [7:0]              position,
    output logic                    halted_bus_active_mode
);
    logic [7:0] feature;
    logic [7:0] threshold;
    logic [7:0] tick_period;
    logic [7:0] scan_factor;
    logic [7:0] click_tone;
    logic [7:0] power_save;
    logic [7:0] held_timeout;
    logic [7:0] mode_control;
    logic [7:0] fault;
    logic [4:0] scan_count;
    logic [2:0] held_pad;
    logic [2:0] wait_pad;
    logic       scan_now;
    logic       cand_valid;
    logic [2:0] cand_pad;
    logic [7:0] next_rdata;
    logic       access;
    rotary_pkg::track_t track;

    function automatic logic [3:0] next_ptr(input logic [3:0] a);
        case (a)
            `ADDR_FAULT:       next_ptr = `ADDR_POSITION;
            `ADDR_FEATURE, `ADDR_THRESHOLD, `ADDR_TICK_PERIOD, `ADDR_SCAN_FACTOR,
            `ADDR_CLICK_TONE, `ADDR_POWER_SAVE, `ADDR_HELD_TIMEOUT:
                               next_ptr = a + 4'h1;
            `ADDR_PART_INFO:   next_ptr = `ADDR_PART_INFO;
            default:           next_ptr = `ADDR_EVENT_QUEUE;
        endcase
    endfunction

    function automatic logic [7:0] pad_strength(input logic [PADS*8-1:0] s,
                                                input int i);
        pad_strength = s[i*8 +: 8];
    endfunction

    wire halted = !mode_control[`BIT_RUN] && mode_control[`BIT_DOZE];
    wire cfg_wr = req.wr && halted;
    assign access = req.wr || req.rd;

    // (RULE1) pointer update
    // (RULE2) burst table walk
    // (RULE3) wrap and stick
    // (RULE20) read advance
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ptr <= `ADDR_EVENT_QUEUE;
        end else if (req.set_ptr) begin
            ptr <= req.ptr;
        end else if (access) begin
            ptr <= next_ptr(ptr);
        end
    end

    // (RULE21) halted-mode write gate
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            feature      <= `RST_FEATURE;
            threshold    <= `RST_THRESHOLD;
            tick_period  <= `RST_TICK_PERIOD;
            scan_factor  <= `RST_SCAN_FACTOR;
            click_tone   <= `RST_CLICK_TONE;
            power_save   <= `RST_POWER_SAVE;
            held_timeout <= `RST_HELD_TIMEOUT;
        end else if (cfg_wr) begin
            case (ptr)
                // (RULE22) unassigned bits dropped
                `ADDR_FEATURE:      feature <= req.wdata & `FEATURE_MASK;
                `ADDR_THRESHOLD:    threshold <= req.wdata;
                `ADDR_TICK_PERIOD:  tick_period <= req.wdata;
                // (RULE18) clamp sample factor
                `ADDR_SCAN_FACTOR:  scan_factor <= (req.wdata > `SCAN_FACTOR_MAX) ?
                                                   `SCAN_FACTOR_MAX : req.wdata;
                `ADDR_CLICK_TONE:   click_tone <= req.wdata;
                `ADDR_POWER_SAVE:   power_save <= req.wdata;
                `ADDR_HELD_TIMEOUT: held_timeout <= req.wdata;
                default: ;
            endcase
        end
    end

    // mode control is writable in any mode
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode_control <= `RST_MODE_CONTROL;
        end else if (req.wr && ptr == `ADDR_MODE_CONTROL) begin
            mode_control <= req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            halted_bus_active_mode <= 1'b1;
        end else begin
            halted_bus_active_mode <= halted;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (ptr)
            `ADDR_EVENT_QUEUE:  next_rdata = event_out.valid ? event_out.data
                                                             : `RST_EVENT_QUEUE;
            `ADDR_FAULT:        next_rdata = fault;
            `ADDR_POSITION:     next_rdata = position;
            `ADDR_FEATURE:      next_rdata = feature;
            `ADDR_THRESHOLD:    next_rdata = threshold;
            `ADDR_TICK_PERIOD:  next_rdata = tick_period;
            `ADDR_SCAN_FACTOR:  next_rdata = scan_factor;
            `ADDR_CLICK_TONE:   next_rdata = click_tone;
            `ADDR_POWER_SAVE:   next_rdata = power_save;
            `ADDR_HELD_TIMEOUT: next_rdata = held_timeout;
            `ADDR_MODE_CONTROL: next_rdata = mode_control;
            `ADDR_PART_INFO:    next_rdata = PART_INFO_VALUE;
            default:            next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // fault flags: never set and always read zero, although writes to locked registers outside halted mode are refused
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fault <= 8'h00;
        end else begin
            fault <= 8'h00;
        end
    end

    // (RULE17) factor is encoding plus one
    // (RULE19) scan every factor ticks
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            scan_count <= 5'h00;
            scan_now   <= 1'b0;
        end else begin
            scan_now <= 1'b0;
            if (tick && mode_control[`BIT_RUN]) begin
                if (scan_count >= scan_factor[4:0]) begin
                    scan_count <= 5'h00;
                    scan_now   <= 1'b1;
                end else begin
                    scan_count <= scan_count + 5'h01;
                end
            end
        end
    end
    assign scan_strobe = scan_now;

    // (RULE6) threshold qualify
    // (RULE7) similar pads rejected
    // (RULE8) clear winner kept
    // (RULE5) between-pad touch untouched
    always_comb begin
        logic [7:0] best;
        logic [7:0] second;
        logic [7:0] s;
        best       = 8'h00;
        second     = 8'h00;
        cand_pad   = 3'h0;
        s          = 8'h00;
        for (int i = 0; i < PADS; i++) begin
            s = pad_strength(strength, i);
            if (s > threshold) begin
                if (s > best) begin
                    second   = best;
                    best     = s;
                    cand_pad = i[2:0];
                end else if (s > second) begin
                    second = s;
                end
            end
        end
        cand_valid = (best > threshold) &&
                     ((second <= threshold) || (best - second >= MARGIN));
    end

    // (RULE12) click gate
    // (RULE4) single position tracking
    // (RULE9) hold first pad
    // (RULE10) later pad silent
    // (RULE11) rollover release then touch
    // (RULE16) detection gate
    // (RULE14) release logging
    // (RULE15) touch logging
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            track     <= rotary_pkg::IDLE;
            held_pad  <= 3'h0;
            wait_pad  <= 3'h0;
            position  <= 8'h00;
            event_out <= '0;
            click     <= 1'b0;
        end else begin
            click <= 1'b0;
            if (event_out.valid && event_ready) begin
                event_out.valid <= 1'b0;
            end
            if (!feature[`BIT_DETECT]) begin
                track    <= rotary_pkg::IDLE;
                position <= 8'h00;
            end else if (scan_now) begin
                case (track)
                    rotary_pkg::IDLE: begin
                        if (cand_valid) begin
                            track    <= rotary_pkg::HELD;
                            held_pad <= cand_pad;
                            position <= 8'h80 | {5'h00, cand_pad};
                            click    <= feature[`BIT_CLICK];
                            if (feature[`BIT_LOG_TOUCH]) begin
                                event_out <= '{valid: 1'b1, data: {5'h00, cand_pad}};
                            end
                        end
                    end
                    rotary_pkg::HELD: begin
                        if (pad_strength(strength, int'(held_pad)) <= threshold) begin
                            position <= 8'h00;
                            if (feature[`BIT_LOG_RELEASE]) begin
                                event_out <= '{valid: 1'b1,
                                               data: 8'h80 | {5'h00, held_pad}};
                            end
                            if (cand_valid) begin
                                track    <= rotary_pkg::WAIT_FREE;
                                wait_pad <= cand_pad;
                            end else begin
                                track <= rotary_pkg::IDLE;
                            end
                        end
                    end
                    rotary_pkg::WAIT_FREE: begin
                        track    <= rotary_pkg::HELD;
                        held_pad <= wait_pad;
                        position <= 8'h80 | {5'h00, wait_pad};
                        click    <= feature[`BIT_CLICK];
                        if (feature[`BIT_LOG_TOUCH]) begin
                            event_out <= '{valid: 1'b1, data: {5'h00, wait_pad}};
                        end
                    end
                    default: track <= rotary_pkg::IDLE;
                endcase
            end
        end
    end

    // (RULE13) calibration enable
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            self_cal_enable <= 1'b0;
        end else begin
            self_cal_enable <= feature[`BIT_SELF_CAL];
        end
    end

    // (RULE2) table check
    a_burst_step: assert property (@(posedge mclk) disable iff (!rstn) // (RULE2)
        (access && !req.set_ptr && ptr == `ADDR_FAULT) |=> ptr == `ADDR_POSITION)
        else $error("burst pointer did not go 1 to 2");
    a_burst_wrap: assert property (@(posedge mclk) disable iff (!rstn) // (RULE3)
        (access && !req.set_ptr && ptr == `ADDR_MODE_CONTROL) |=> ptr == `ADDR_EVENT_QUEUE)
        else $error("burst pointer did not wrap after 0x0A");
    a_burst_stick: assert property (@(posedge mclk) disable iff (!rstn) // (RULE3)
        (access && !req.set_ptr && ptr == `ADDR_PART_INFO) |=> ptr == `ADDR_PART_INFO)
        else $error("burst pointer left 0x0B");
    a_factor_clamp: assert property (@(posedge mclk) disable iff (!rstn) // (RULE18)
        scan_factor <= `SCAN_FACTOR_MAX)
        else $error("scan factor out of range");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn) // (RULE22)
        (feature & ~`FEATURE_MASK) == 8'h00)
        else $error("reserved feature bits set");
    a_write_locked: assert property (@(posedge mclk) disable iff (!rstn) // (RULE21)
        (req.wr && !halted && ptr == `ADDR_THRESHOLD) |=> $stable(threshold))
        else $error("threshold written outside halted mode");
    a_detect_off: assert property (@(posedge mclk) disable iff (!rstn) // (RULE16)
        !feature[`BIT_DETECT] |=> position == 8'h00)
        else $error("touch reported while detection off");
    a_click_gate: assert property (@(posedge mclk) disable iff (!rstn) // (RULE12)
        click |-> $past(feature[`BIT_CLICK]))
        else $error("click with sounder disabled");
    a_one_position: assert property (@(posedge mclk) disable iff (!rstn) // (RULE4)
        (position == 8'h00) || (position[7:3] == 5'h10))
        else $error("position field invalid");
    a_held_kept: assert property (@(posedge mclk) disable iff (!rstn) // (RULE9)
        (scan_now && feature[`BIT_DETECT] && track == rotary_pkg::HELD &&
         pad_strength(strength, int'(held_pad)) > threshold) |=> $stable(position))
        else $error("held pad report changed");
    a_touch_log: assert property (@(posedge mclk) disable iff (!rstn) // (RULE15)
        (scan_now && feature[`BIT_DETECT] && feature[`BIT_LOG_TOUCH] &&
         track == rotary_pkg::IDLE && cand_valid) |=> (event_out.valid &&
         event_out.data == {5'h00, $past(cand_pad)}))
        else $error("new touch not logged");
    a_release_log: assert property (@(posedge mclk) disable iff (!rstn) // (RULE14)
        (scan_now && feature[`BIT_DETECT] && feature[`BIT_LOG_RELEASE] &&
         track == rotary_pkg::HELD && pad_strength(strength, int'(held_pad)) <= threshold)
        |=> (event_out.valid && event_out.data[`EVT_RELEASE_FLAG]))
        else $error("release not logged");
endmodule // rotary_touch_decode_regmap
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rotary_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    logic                 mclk;
    logic                 rstn;
    logic                 tick;
    logic                 event_ready;
    logic [63:0]          strength;
    rotary_pkg::reg_req_t req;
    rotary_pkg::event_t   event_out;
    logic [7:0]           rdata;
    logic [7:0]           position;
    logic [7:0]           d;
    logic [3:0]           ptr;
    logic                 scan_strobe;
    logic                 click;
    logic                 self_cal;
    logic                 halted;
    logic [7:0]           got[$];
    logic [7:0]           exp[$];
    int                   err_count, cmp_count, cyc, clicks, strobes, mptr, mhalt, i;
    int                   seed = 47180;
    int                   sv[8];
    int                   mr[12] = '{'h40, 0, 0, 'h81, 0, 5, 1, 1, 0, 0, 'h14, 'h5A};
    rotary_touch_decode_regmap dut (.mclk(mclk), .rstn(rstn), .tick(tick), .req(req),
        .strength(strength), .event_ready(event_ready), .rdata(rdata), .ptr(ptr),
        .scan_strobe(scan_strobe), .click(click), .self_cal_enable(self_cal),
        .event_out(event_out), .position(position), .halted_bus_active_mode(halted));
    host_model host (.mclk(mclk), .rdata(rdata), .req(req));
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (click === 1'b1) clicks++;
        if (scan_strobe === 1'b1) strobes++;
        if (event_out.valid === 1'b1 && event_ready === 1'b1) got.push_back(event_out.data);
        if (cyc >= 30000) begin
            err_count++;
            summarize();
        end
    end
    always @(negedge mclk) tick <= (cyc % 4 == 0);
    function automatic int nxt(input int a);
        if (a == 1) return 2;
        if (a >= 3 && a <= 9) return a + 1;
        if (a == 11) return 11;
        return 0;
    endfunction
    task automatic acc(input bit s, input bit w, input int v);
        host.issue(s, w, !s && !w, v[7:0], d);
        if (s) mptr = v;
        else begin
            if (!w) `CHK(d, mr[mptr][7:0])
            if (w && mptr == 10) begin
                mr[10] = v;
                mhalt = !v[`BIT_RUN] && v[`BIT_DOZE];
            end else if (w && mhalt && mptr >= 3 && mptr <= 9)
                mr[mptr] = mptr == 3 ? v & `FEATURE_MASK : (mptr == 6 && v[7:0] > 31 ? 31 : v[7:0]);
            mptr = nxt(mptr);
        end
        `CHK(ptr, mptr[3:0])
    endtask
    task automatic idle();
        host.issue(0, 0, 0, $random(seed), d);
    endtask
    task automatic wreg(input int a, input int v);
        acc(1, 0, a);
        acc(0, 1, v);
        idle();
    endtask
    task automatic rreg(input int a);
        acc(1, 0, a);
        acc(0, 0, 0);
        idle();
    endtask
    task automatic scans(input int n);
        repeat (n) begin
            @(posedge mclk);
            while (scan_strobe !== 1'b1) @(posedge mclk);
        end
        repeat (2) @(negedge mclk);
    endtask
    task automatic rate(input int f);
        wreg(6, f);
        wreg(10, 'h15);
        scans(2);
        strobes = 0;
        repeat (16 * (f + 1)) @(posedge mclk);
        #1;
        `CHK(strobes, 4)
        wreg(10, 'h04);
    endtask
    task automatic step(input int p, input int v, input int pos);
        sv[p] = v;
        @(negedge mclk);
        for (i = 0; i < 8; i++) strength[i*8+:8] = sv[i] != 0 ? sv[i] : $random(seed) & 'h3F;
        scans(3);
        `CHK(position, pos[7:0])
    endtask
    task automatic summarize();
        $display("compares=%0d errors=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        rstn = 0;
        event_ready = 0;
        strength = '0;
        mhalt = 1;
        repeat (12) @(negedge mclk);
        rstn = 1;
        event_ready = 1;
        for (int a = 0; a < 12; a++) rreg(a);
        acc(1, 0, 3);
        for (int a = 3; a < 10; a++) acc(0, 1, a == 5 ? ($random(seed) & 'hFF) % 27 : $random(seed));
        acc(0, 1, 'h04);
        idle();
        acc(1, 0, 3);
        repeat (8) acc(0, 0, 0);
        idle();
        acc(1, 0, 11);
        acc(0, 1, 'h00);
        acc(0, 1, 'hFF);
        idle();
        foreach (sv[k]) wreg(6, k == 0 ? 'h1F : k == 1 ? 'h20 : 'hF0 + k);
        rreg(6);
        wreg(10, 'h15);
        `CHK(halted, 1'b0)
        wreg(4, 'h33);
        rreg(4);
        wreg(10, 'h04);
        `CHK(halted, 1'b1)
        rate(2);
        rate(0);
        wreg(4, 'h40);
        wreg(3, 'h9D);
        wreg(10, 'h15);
        `CHK(self_cal, 1'b1)
        clicks = 0;
        got.delete();
        step(3, 'h40, 0);
        step(3, 'h80, 'h83);
        step(5, 'hC0, 'h83);
        step(5, 0, 'h83);
        step(5, 'hC0, 'h83);
        step(3, 0, 'h85);
        step(5, 0, 0);
        sv[2] = 'h90;
        step(6, 'h90, 0);
        step(2, 'h60, 'h86);
        step(2, 0, 'h86);
        step(6, 0, 0);
        exp = '{'h03, 'h83, 'h05, 'h85, 'h06, 'h86};
        `CHK(got.size(), exp.size())
        foreach (exp[k]) `CHK(got[k], exp[k])
        `CHK(clicks, 3)
        wreg(10, 'h04);
        wreg(3, 'h01);
        `CHK(self_cal, 1'b0)
        wreg(10, 'h15);
        clicks = 0;
        step(4, 'hA0, 'h84);
        mr[2] = 'h84;
        rreg(2);
        mr[2] = 0;
        step(4, 0, 0);
        wreg(10, 'h04);
        wreg(3, 'h8C);
        wreg(10, 'h15);
        step(1, 'hF0, 0);
        step(1, 0, 0);
        `CHK(clicks, 0)
        `CHK(got.size(), exp.size())
        summarize();
    end
endmodule // tb_top
`default_nettype wire
